// *** usc_consts.svh ***
/*
 Offsets, field positions and timing counts of the serial port.
 Assumes a 25 MHz core clock and byte addresses on an 8-bit register address.
*/
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define USC_OFF_STA 8'h00
`define USC_OFF_MODE 8'h04
`define USC_OFF_TXDATA 8'h08
`define USC_OFF_RXDATA 8'h0C
`define USC_OFF_IRQ_STAT 8'h10
`define USC_OFF_IRQ_MASK 8'h14

// ----------------------------------------------------------------------------
// status/control fields
// ----------------------------------------------------------------------------
`define USC_STA_MASK_HI 31
`define USC_STA_MASK_LO 24
`define USC_STA_ADDR_HI 23
`define USC_STA_ADDR_LO 16
`define USC_STA_TXISEL_HI 15
`define USC_STA_TXISEL_LO 14
`define USC_STA_TXINV 13
`define USC_STA_RXEN 12
`define USC_STA_BRK 11
`define USC_STA_TXEN 10
`define USC_STA_TXBF 9
`define USC_STA_TX_ALL_EMPTY 8
`define USC_STA_RXISEL_HI 7
`define USC_STA_RXISEL_LO 6
`define USC_STA_ADDRESS_DETECT_ENABLE 5
`define USC_STA_RX_IDLE_FLAG 4
`define USC_STA_PARITY_ERROR_FLAG 3
`define USC_STA_FRAMING_ERROR_FLAG 2
`define USC_STA_OVERRUN_FLAG 1
`define USC_STA_RXDA 0

// ----------------------------------------------------------------------------
// mode fields
// ----------------------------------------------------------------------------
`define USC_MODE_ON 15
`define USC_MODE_INFRARED_CODEC_ENABLE 12
`define USC_MODE_PDSEL_HI 2
`define USC_MODE_PDSEL_LO 1
`define USC_MODE_STSEL 0

// ----------------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------------
`define USC_IRQ_RX 0
`define USC_IRQ_OVR 1
`define USC_IRQ_ERR 2
`define USC_IRQ_TXDONE 3
`define USC_IRQ_W 4

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define USC_CLK_NS 40
`define USC_BIT_NS 8680
`define USC_BIT_CYC (`USC_BIT_NS / `USC_CLK_NS)
`define USC_IR_CYC ((`USC_BIT_CYC * 3) / 16)
`define USC_RX_DEPTH 4
`define USC_BREAK_ZEROS 12

`endif

// *** usc_pkg.sv ***
/*
 Types of the serial port status and control block.
 Assumes usc_consts.svh for all numeric values.
*/
package usc_pkg;

   typedef enum logic [1:0] {
      USC_PD_8N,
      USC_PD_8E,
      USC_PD_8O,
      USC_PD_9N
   } usc_pdsel_e;

   typedef struct packed {
      logic on;
      logic infrared_codec_enable;
      usc_pdsel_e pdsel;
      logic stsel;
   } usc_mode_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } usc_bus_s;

   typedef struct packed {
      logic [8:0] data;
      logic parity_error_flag;
      logic framing_error_flag;
   } usc_rxchar_s;

endpackage

// *** usc_tx_shift.sv ***
/*
 Transmit buffer, shift register, break sender and line encoder.
 Assumes the parent only writes while the buffer is not full.
*/
`timescale 1ns/100ps
`include "usc_consts.svh"

module usc_tx_shift (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire usc_pkg::usc_mode_s mode,
   input wire logic invert,
   input wire logic wrValid,
   input wire logic [8:0] wrData,
   input wire logic breakReq,
   output logic bufFull,
   output logic allEmpty,
   output logic breakDone,
   output logic txLevel
);
   import usc_pkg::*;

   logic [8:0] bufReg;
   logic bufValidReg;
   logic [13:0] shiftReg;
   logic [3:0] bitsLeftReg;
   logic [7:0] cntReg;
   logic busyReg;
   logic breakRunReg;
   logic bitEnd;
   logic rawBit;
   logic irPulse;
   logic breakGo;

   // ------------------------------------------------------------------------
   // frame builder, lsb first, padded with stop level
   // ------------------------------------------------------------------------
   function automatic logic [13:0] buildFrame(input logic [8:0] d, input usc_mode_s m);
      logic ninth;
      ninth = 1'b1;
      case (m.pdsel)
         USC_PD_8E: ninth = ^d[7:0];
         USC_PD_8O: ninth = ~(^d[7:0]);
         USC_PD_9N: ninth = d[8];
         default: ninth = 1'b1;
      endcase
      return {4'hF, ninth, d[7:0], 1'b0};
   endfunction

   assign bitEnd = busyReg && (cntReg == 8'(`USC_BIT_CYC - 1));
   assign bufFull = bufValidReg; // R6
   assign allEmpty = !busyReg && !bufValidReg; // R7
   // request drops a cycle after completion; without this a second break follows
   assign breakGo = breakReq && !breakDone; // R4

   // ------------------------------------------------------------------------
   // buffer
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst || !enable) begin
         bufValidReg <= 1'b0; // R5
         bufReg <= 9'h000;
      end else if (wrValid) begin
         bufValidReg <= 1'b1;
         bufReg <= wrData;
      end else if (!busyReg && !breakGo && bufValidReg) begin
         bufValidReg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // shifter
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      breakDone <= 1'b0;
      if (sys_rst || !enable) begin
         busyReg <= 1'b0; // R5
         breakRunReg <= 1'b0;
         shiftReg <= 14'h3FFF;
         bitsLeftReg <= 4'h0;
         cntReg <= 8'h00;
      end else if (!busyReg) begin
         cntReg <= 8'h00;
         if (breakGo) begin
            // start bit plus twelve zeros, then stop
            shiftReg <= {1'b1, 13'h0000}; // R4
            bitsLeftReg <= 4'(`USC_BREAK_ZEROS + 2);
            busyReg <= 1'b1;
            breakRunReg <= 1'b1;
         end else if (bufValidReg) begin
            shiftReg <= buildFrame(bufReg, mode);
            bitsLeftReg <= 4'd10 + 4'(mode.pdsel != USC_PD_8N) + 4'(mode.stsel);
            busyReg <= 1'b1;
         end
      end else if (bitEnd) begin
         cntReg <= 8'h00;
         shiftReg <= {1'b1, shiftReg[13:1]};
         bitsLeftReg <= bitsLeftReg - 4'h1;
         if (bitsLeftReg == 4'h1) begin
            busyReg <= 1'b0;
            breakRunReg <= 1'b0;
            breakDone <= breakRunReg; // R4
         end
      end else begin
         cntReg <= cntReg + 8'h01;
      end
   end

   // ------------------------------------------------------------------------
   // line encoder
   // ------------------------------------------------------------------------
   assign rawBit = busyReg ? shiftReg[0] : 1'b1;
   // a zero bit becomes a short pulse, idle stays quiet before inversion
   assign irPulse = !rawBit && (cntReg < 8'(`USC_IR_CYC));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txLevel <= 1'b1;
      end else if (mode.infrared_codec_enable) begin
         txLevel <= irPulse ^ invert; // R2
      end else begin
         txLevel <= rawBit ^ invert; // R1
      end
   end
endmodule

// *** usc_status_control.sv ***
/*
 Serial port status/control: registers, receiver, receive buffer, interrupt.
 Assumes a single-cycle register master and rx pin synchronous to clk.
*/
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "usc_consts.svh"

// ----------------------------------------------------------------------------
// How it works
// R1: plain mode, invert bit makes idle low
// R2: infrared mode, invert bit makes idle high
// R3: receiver enable gates use of rx pin
// R4: break sends start, twelve zeros, stop
// R5: tx enable controls pin, clear aborts
// R6: buffer full flag while no room
// R7: all-empty flag when shifter and buffer empty
// R8: rx threshold selects irq fill level
// R9: address detect takes ninth bit set
// R10: rx idle flag low while receiving
// R11: parity error for current character
// R12: framing error for current character
// R13: overrun set by hardware, clear flushes
// R14: data available while buffer not empty
// R15: address compared under mask bits
// R16: code 11 is nine bits, no parity
// R17: receive buffer holds four characters
// R18: error flags follow buffer head
// ----------------------------------------------------------------------------

module usc_status_control (
   input wire logic clk,
   input wire logic sys_rst,
   input wire usc_pkg::usc_bus_s bus,
   output logic [31:0] rdData,
   output logic irq,
   input wire logic rxPin,
   output logic txPin,
   output logic txOe
);
   import usc_pkg::*;

   typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} usc_rx_e;

   // ------------------------------------------------------------------------
   // control state
   // ------------------------------------------------------------------------
   usc_mode_s modeReg;
   logic [7:0] maskReg;
   logic [7:0] addrReg;
   logic [1:0] txIselReg;
   logic txInvReg;
   logic rxEnReg;
   logic breakReg;
   logic txEnReg;
   logic [1:0] rxIselReg;
   logic addrDetReg;
   logic overrunReg;
   logic [`USC_IRQ_W-1:0] irqStatReg;
   logic [`USC_IRQ_W-1:0] irqMaskReg;

   logic wrSta;
   logic rdRx;
   logic rdIrq;
   logic ovrClear;
   logic txActive;
   logic rxActive;
   logic txFull;
   logic txEmpty;
   logic txEmptyDly;
   logic breakDone;
   logic txLevel;

   // ------------------------------------------------------------------------
   // receiver state
   // ------------------------------------------------------------------------
   usc_rx_e rxState;
   logic [7:0] rxCntReg;
   logic [3:0] rxIdxReg;
   logic [9:0] rxBitsReg;
   logic rxMatchReg;
   logic rxDone;
   logic rxParErr;
   logic rxIsAddr;
   logic rxKeep;
   logic [3:0] rxNumBits;

   // ------------------------------------------------------------------------
   // receive buffer
   // ------------------------------------------------------------------------
   usc_rxchar_s fifoMem [`USC_RX_DEPTH];
   logic [1:0] wrPtrReg;
   logic [1:0] rdPtrReg;
   logic [2:0] countReg;
   logic push;
   logic pop;
   usc_rxchar_s head;
   usc_rxchar_s rxChar;
   logic rxThr;

   function automatic logic hit(input usc_bus_s b, input logic [7:0] off);
      return b.addr == off;
   endfunction

   // fill-level threshold of the receive interrupt; reserved code never fires
   function automatic logic rxThreshold(input logic [1:0] sel, input logic [2:0] cnt);
      case (sel)
         2'b00: return cnt != 3'h0;
         2'b01: return cnt >= 3'(`USC_RX_DEPTH / 2);
         2'b10: return cnt >= 3'((`USC_RX_DEPTH * 3) / 4);
         default: return 1'b0;
      endcase
   endfunction

   assign wrSta = bus.wr && hit(bus, `USC_OFF_STA);
   assign rdRx = bus.rd && hit(bus, `USC_OFF_RXDATA);
   assign rdIrq = bus.rd && hit(bus, `USC_OFF_IRQ_STAT);
   // only a write of zero over a set flag flushes the receiver
   assign ovrClear = wrSta && overrunReg && !bus.wdata[`USC_STA_OVERRUN_FLAG]; // R13
   assign txActive = modeReg.on && txEnReg;
   assign rxActive = modeReg.on && rxEnReg; // R3

   // ------------------------------------------------------------------------
   // software-written fields
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         modeReg <= '0;
         maskReg <= 8'h00;
         addrReg <= 8'h00;
         txIselReg <= 2'h0;
         txInvReg <= 1'b0;
         rxEnReg <= 1'b0;
         txEnReg <= 1'b0;
         rxIselReg <= 2'h0;
         addrDetReg <= 1'b0;
         irqMaskReg <= '0;
      end else if (bus.wr) begin
         if (hit(bus, `USC_OFF_MODE)) begin
            modeReg.on <= bus.wdata[`USC_MODE_ON];
            modeReg.infrared_codec_enable <= bus.wdata[`USC_MODE_INFRARED_CODEC_ENABLE];
            modeReg.pdsel <= usc_pdsel_e'(bus.wdata[`USC_MODE_PDSEL_HI:`USC_MODE_PDSEL_LO]);
            modeReg.stsel <= bus.wdata[`USC_MODE_STSEL];
         end
         if (wrSta) begin
            maskReg <= bus.wdata[`USC_STA_MASK_HI:`USC_STA_MASK_LO];
            addrReg <= bus.wdata[`USC_STA_ADDR_HI:`USC_STA_ADDR_LO];
            txIselReg <= bus.wdata[`USC_STA_TXISEL_HI:`USC_STA_TXISEL_LO];
            txInvReg <= bus.wdata[`USC_STA_TXINV];
            rxEnReg <= bus.wdata[`USC_STA_RXEN];
            txEnReg <= bus.wdata[`USC_STA_TXEN];
            rxIselReg <= bus.wdata[`USC_STA_RXISEL_HI:`USC_STA_RXISEL_LO];
            addrDetReg <= bus.wdata[`USC_STA_ADDRESS_DETECT_ENABLE];
         end
         if (hit(bus, `USC_OFF_IRQ_MASK)) begin
            irqMaskReg <= bus.wdata[`USC_IRQ_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------------------
   // break request: set by software, cleared by hardware at completion
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         breakReg <= 1'b0;
      end else if (wrSta) begin
         breakReg <= bus.wdata[`USC_STA_BRK];
      end else if (breakDone) begin
         breakReg <= 1'b0; // R4
      end
   end

   // ------------------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------------------
   usc_tx_shift u_tx (
      .clk(clk),
      .sys_rst(sys_rst),
      .enable(txActive),
      .mode(modeReg),
      .invert(txInvReg),
      .wrValid(bus.wr && hit(bus, `USC_OFF_TXDATA) && txActive && !txFull),
      .wrData(bus.wdata[8:0]),
      .breakReq(breakReg),
      .bufFull(txFull),
      .allEmpty(txEmpty),
      .breakDone(breakDone),
      .txLevel(txLevel)
   );

   assign txPin = txLevel;
   assign txOe = txActive; // R5

   // ------------------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------------------
   assign rxNumBits = (modeReg.pdsel == USC_PD_8N) ? 4'd8 : 4'd9;
   assign rxDone = (rxState == RX_STOP) && (rxCntReg == 8'(`USC_BIT_CYC - 1));
   always_comb begin
      case (modeReg.pdsel)
         USC_PD_8E: rxParErr = ^rxBitsReg[8:0]; // R11
         USC_PD_8O: rxParErr = ~(^rxBitsReg[8:0]);
         default: rxParErr = 1'b0;
      endcase
   end
   // ninth bit marks an address only in nine-bit mode
   assign rxIsAddr = (modeReg.pdsel == USC_PD_9N) && rxBitsReg[8]; // R16 R9
   always_comb begin
      rxKeep = 1'b1;
      if (addrDetReg && modeReg.pdsel == USC_PD_9N) begin
         rxKeep = rxIsAddr ? (((rxBitsReg[7:0] ^ addrReg) & maskReg) == 8'h00) // R15
                           : rxMatchReg;
      end
   end
   assign rxChar.data = (modeReg.pdsel == USC_PD_9N) ? rxBitsReg[8:0] : {1'b0, rxBitsReg[7:0]};
   assign rxChar.parity_error_flag = rxParErr;
   assign rxChar.framing_error_flag = !rxPin; // R12

   always_ff @(posedge clk) begin
      if (sys_rst || !rxActive || ovrClear) begin
         rxState <= RX_IDLE; // R3 R13
         rxCntReg <= 8'h00;
         rxIdxReg <= 4'h0;
         rxBitsReg <= 10'h000;
      end else begin
         rxCntReg <= rxCntReg + 8'h01;
         case (rxState)
            RX_IDLE: begin
               rxCntReg <= 8'h00;
               if (!rxPin) begin
                  rxState <= RX_START;
               end
            end
            RX_START: begin
               // mid-start recheck rejects glitches
               if (rxCntReg == 8'(`USC_BIT_CYC / 2)) begin
                  rxCntReg <= 8'h00;
                  rxIdxReg <= 4'h0;
                  rxState <= rxPin ? RX_IDLE : RX_BITS;
               end
            end
            RX_BITS: begin
               if (rxCntReg == 8'(`USC_BIT_CYC - 1)) begin
                  rxCntReg <= 8'h00;
                  rxBitsReg[rxIdxReg] <= rxPin;
                  rxIdxReg <= rxIdxReg + 4'h1;
                  if (rxIdxReg == rxNumBits - 4'h1) begin
                     rxState <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rxDone) begin
                  rxState <= RX_IDLE;
               end
            end
            default: rxState <= RX_IDLE;
         endcase
      end
   end

   // an accepted address opens the gate for following data characters
   always_ff @(posedge clk) begin
      if (sys_rst || !addrDetReg) begin
         rxMatchReg <= 1'b0;
      end else if (rxDone && rxIsAddr) begin
         rxMatchReg <= rxKeep; // R9
      end
   end

   // ------------------------------------------------------------------------
   // receive buffer, four characters
   // ------------------------------------------------------------------------
   assign push = rxDone && rxKeep && !overrunReg && countReg != 3'(`USC_RX_DEPTH); // R17
   assign pop = rdRx && countReg != 3'h0;
   assign head = fifoMem[rdPtrReg];

   always_ff @(posedge clk) begin
      if (push) begin
         fifoMem[wrPtrReg] <= rxChar;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || ovrClear) begin
         wrPtrReg <= 2'h0; // R13
         rdPtrReg <= 2'h0;
         countReg <= 3'h0;
      end else begin
         wrPtrReg <= wrPtrReg + 2'(push);
         rdPtrReg <= rdPtrReg + 2'(pop);
         countReg <= countReg + 3'(push) - 3'(pop);
      end
   end

   // ------------------------------------------------------------------------
   // overrun: hardware sets, only software clears, set wins
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         overrunReg <= 1'b0;
      end else if (rxDone && rxKeep && countReg == 3'(`USC_RX_DEPTH)) begin
         overrunReg <= 1'b1; // R13
      end else if (ovrClear) begin
         overrunReg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // interrupt status, cleared by reading it
   // ------------------------------------------------------------------------
   assign rxThr = rxThreshold(rxIselReg, countReg); // R8

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqStatReg <= '0;
         txEmptyDly <= 1'b1;
      end else begin
         txEmptyDly <= txEmpty;
         irqStatReg <= (rdIrq ? '0 : irqStatReg)
            | ({`USC_IRQ_W{1'b0}} | (`USC_IRQ_W'(rxThr) << `USC_IRQ_RX))
            | (`USC_IRQ_W'(rxDone && rxKeep && countReg == 3'(`USC_RX_DEPTH)) << `USC_IRQ_OVR)
            | (`USC_IRQ_W'(push && (rxChar.parity_error_flag || rxChar.framing_error_flag)) << `USC_IRQ_ERR)
            | (`USC_IRQ_W'(txEmpty && !txEmptyDly) << `USC_IRQ_TXDONE);
      end
   end

   assign irq = |(irqStatReg & irqMaskReg);

   // ------------------------------------------------------------------------
   // read data, one cycle after the strobe
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData <= 32'h0000_0000;
      end else begin
         rdData <= 32'h0000_0000;
         if (bus.rd) begin
            case (bus.addr)
               `USC_OFF_STA: begin
                  rdData <= {maskReg, addrReg, txIselReg, txInvReg, rxEnReg,
                             breakReg, txEnReg,
                             txFull, // R6
                             txEmpty, // R7
                             rxIselReg, addrDetReg,
                             rxState == RX_IDLE, // R10
                             countReg != 3'h0 && head.parity_error_flag, // R18
                             countReg != 3'h0 && head.framing_error_flag, // R18
                             overrunReg,
                             countReg != 3'h0}; // R14
               end
               `USC_OFF_MODE: begin
                  rdData <= 32'(modeReg.on) << `USC_MODE_ON
                          | 32'(modeReg.infrared_codec_enable) << `USC_MODE_INFRARED_CODEC_ENABLE
                          | 32'(modeReg.pdsel) << `USC_MODE_PDSEL_LO
                          | 32'(modeReg.stsel) << `USC_MODE_STSEL;
               end
               `USC_OFF_RXDATA: rdData <= (countReg != 3'h0) ? 32'(head.data) : 32'h0;
               `USC_OFF_IRQ_STAT: rdData <= 32'(irqStatReg);
               `USC_OFF_IRQ_MASK: rdData <= 32'(irqMaskReg);
               default: rdData <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// *** usc_monitor.sv ***
/*
 Checker on the serial port top ports, bound at the foot.
 Assumes one-cycle register reads and the offsets of usc_consts.svh.
*/
`timescale 1ns/100ps
`include "usc_consts.svh"
module usc_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire usc_pkg::usc_bus_s bus,
   input wire logic [31:0] rdData,
   input wire logic irq,
   input wire logic txPin,
   input wire logic txOe
);
   import usc_pkg::*;
   logic onReg, irReg, enReg, invReg;
   int runCnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // software's copy of enables and line polarity
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {onReg, irReg, enReg, invReg} <= 4'h0;
      end else if (bus.wr && bus.addr == 8'h04) begin
         {onReg, irReg} <= {bus.wdata[15], bus.wdata[12]};
      end else if (bus.wr && bus.addr == 8'h00) begin
         {enReg, invReg} <= {bus.wdata[10], bus.wdata[13]};
      end
   end
   // a break is the longest legal stretch away from idle
   always_ff @(posedge clk) begin
      if (sys_rst || txPin == (irReg ? invReg : !invReg)) begin
         runCnt <= 0;
      end else begin
         runCnt <= runCnt + 1;
      end
   end
   sequence staRd;
      $past(bus.rd) && $past(bus.addr) == 8'h00;
   endsequence
   a_reset_quiet: assert property ($fell(sys_rst) |-> txPin && !txOe && !irq && !rdData)
      else $error("outputs not idle after reset");
   a_read_pulse: assert property (!$past(bus.rd) |-> rdData == 32'h0)
      else $error("read data outside its slot");
   a_full_empty: assert property (staRd |-> !(rdData[9] && rdData[8]))
      else $error("buffer full and all empty together");
   a_error_head: assert property (staRd |-> rdData[0] || rdData[3:2] == 2'b00)
      else $error("error flag with empty buffer");
   a_oe_enable: assert property (txOe == (onReg && enReg))
      else $error("pin drive does not follow enables");
   a_break_length: assert property (runCnt <= 14 * `USC_BIT_CYC + 2)
      else $error("line away from idle too long");
   a_rx_width: assert property ($past(bus.rd) && $past(bus.addr) == 8'h0C
      |-> rdData < 32'h200) else $error("receive data too wide");
   a_mask_quiet: assert property (bus.wr && bus.addr == 8'h14 && bus.wdata == 32'h0
      |=> !irq) else $error("masked interrupt still high");
   c_break: cover property (runCnt == 13 * `USC_BIT_CYC);
   c_irq: cover property ($rose(irq));
   c_oe_off: cover property ($fell(txOe));
endmodule

bind usc_status_control usc_monitor i_usc_monitor (.clk, .sys_rst, .bus, .rdData, .irq,
   .txPin, .txOe);

// *** usc_node.sv ***
/*
 Remote serial node: sends frames on rxPin, decodes frames seen on txPin.
 Assumes plain polarity, no infrared coding, one stop bit on the line.
*/
`timescale 1ns/100ps
`include "usc_consts.svh"
module usc_node (
   input wire logic clk,
   input wire logic txPin,
   output logic rxPin
);
   logic [8:0] got;
   int frames = 0;
   initial rxPin = 1'b1;
   // start, n slots lsb first (the last is the stop), then one idle bit
   task automatic send(input logic [10:0] bits, input int n);
      rxPin <= 1'b0;
      repeat (`USC_BIT_CYC) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rxPin <= bits[i];
         repeat (`USC_BIT_CYC) @(posedge clk);
      end
      rxPin <= 1'b1;
      repeat (`USC_BIT_CYC) @(posedge clk);
   endtask
   // mid-bit sampling; a break reads as zero data with a low stop slot
   always begin
      @(negedge txPin);
      repeat (`USC_BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (`USC_BIT_CYC) @(posedge clk);
         got[i] = txPin;
      end
      frames++;
   end
endmodule

// *** tb.sv ***
/*
 Self-checking bench for the serial port status/control block.
 Assumes usc_monitor binds itself and usc_node stands on the line.
*/
`timescale 1ns/100ps
`include "usc_consts.svh"
module tb;
   import usc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   usc_bus_s bus = '0;
   logic [31:0] rdData, v;
   logic irq, rxPin, txPin, txOe;
   logic [8:0] adr [4] = '{9'h143, 9'h055, 9'h1C2, 9'h066};
   int fails = 0;
   int num_checks = 0;
   int n;
   usc_status_control i_usc_status_control (.clk, .sys_rst, .bus, .rdData, .irq, .rxPin,
      .txPin, .txOe);
   usc_node i_usc_node (.clk, .txPin, .rxPin);
   initial forever #20 clk = ~clk;
   initial begin
      #(40 * 90000);
      fails++;
      end_sim();
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   // idle cycle after each access so no strobe is driven twice at one edge
   task automatic rw(input logic [7:0] a, input logic [31:0] d, input logic w);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      bus <= '0;
      #1 v = rdData;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rw(a, 32'h0, 1'b0);
      chk(v & m, e);
   endtask
   task automatic waitf(input int f);
      for (int k = 0; k < 9000 && i_usc_node.frames < f; k++) @(posedge clk);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rc(8'h00, 32'hFFFFFFFF, 32'h110);
      rc(8'h18, 32'hFFFFFFFF, 32'h0);
      rw(8'h04, 32'h8000, 1'b1);
      rw(8'h00, 32'h1400, 1'b1);
      chk(txOe, 1'b1);
      rw(8'h08, 32'hA5, 1'b1);
      rc(8'h00, 32'h300, 32'h0);
      for (int k = 0; k < 9 && v[9] !== 1'b1; k++) begin
         rw(8'h08, 32'h5A, 1'b1);
         rw(8'h00, 32'h0, 1'b0);
      end
      chk(v[9], 1'b1);
      rw(8'h00, 32'h1000, 1'b1);
      rc(8'h00, 32'h300, 32'h100);
      chk(txOe, 1'b0);
      repeat (2500) @(posedge clk);
      rw(8'h00, 32'h1400, 1'b1);
      n = i_usc_node.frames;
      rw(8'h08, 32'h3C, 1'b1);
      rw(8'h00, 32'h1C00, 1'b1);
      waitf(n + 1);
      chk(i_usc_node.got, 9'h13C);
      waitf(n + 2);
      chk(i_usc_node.got, 9'h000);
      repeat (7 * `USC_BIT_CYC) @(posedge clk);
      rc(8'h00, 32'h800, 32'h0);
      rw(8'h14, 32'h1, 1'b1);
      fork
         i_usc_node.send(11'h161, 9);
         begin
            repeat (500) @(posedge clk);
            rc(8'h00, 32'h10, 32'h0);
         end
      join
      chk(i_usc_node.frames, n + 2);
      rc(8'h00, 32'h11, 32'h11);
      rc(8'h0C, 32'hFF, 32'h61);
      rc(8'h00, 32'h1, 32'h0);
      for (int k = 1; k < 6; k++) begin
         i_usc_node.send(11'h120 + 11'(k), 9);
         for (int c = 0; c < 3 && k < 5; c++) begin
            rw(8'h00, 32'h1400 | (c << 6), 1'b1);
            rw(8'h10, 32'h0, 1'b0);
            chk(irq, k > c);
         end
      end
      rw(8'h14, 32'h0, 1'b1);
      chk(irq, 1'b0);
      rc(8'h10, 32'h2, 32'h2);
      rc(8'h00, 32'h3, 32'h3);
      rw(8'h00, 32'h1480, 1'b1);
      rc(8'h00, 32'h3, 32'h0);
      rw(8'h10, 32'h0, 1'b0);
      rc(8'h10, 32'h3, 32'h0);
      rw(8'h04, 32'h8002, 1'b1);
      i_usc_node.send(11'h333, 10);
      i_usc_node.send(11'h033, 10);
      rc(8'h00, 32'hC, 32'h8);
      rc(8'h0C, 32'hFF, 32'h33);
      rc(8'h00, 32'hC, 32'h4);
      rc(8'h10, 32'hC, 32'h4);
      rw(8'h0C, 32'h0, 1'b0);
      rw(8'h00, 32'h0400, 1'b1);
      i_usc_node.send(11'h177, 9);
      rc(8'h00, 32'h1, 32'h0);
      rw(8'h04, 32'h8006, 1'b1);
      rw(8'h00, 32'hFE421420, 1'b1);
      foreach (adr[k]) i_usc_node.send({2'b01, adr[k]}, 10);
      rc(8'h0C, 32'h1FF, 32'h143);
      rc(8'h0C, 32'h1FF, 32'h055);
      rc(8'h00, 32'h1, 32'h0);
      for (int k = 0; k < 4; k++) begin
         rw(8'h04, {19'h0, k[1], 12'h0}, 1'b1);
         rw(8'h00, {18'h0, k[0], 13'h0}, 1'b1);
         repeat (2) @(posedge clk);
         chk(txPin, k[1] ? k[0] : !k[0]);
      end
      end_sim();
   end
endmodule
